//--- hdl/sqs_pkg.sv
// Shared constants and types of the conversion sequencer
package sqs_pkg;
    localparam int SQS_WIDTH = 16;
    localparam int SQS_STEPS = 17;
    localparam int SQS_STEP_W = 5;
    localparam int SQS_REF_CLK_KHZ = 200000;
    localparam int SQS_INT_CLK_KHZ = 1600;
    localparam int SQS_INT_PERIOD_CYC = SQS_REF_CLK_KHZ / SQS_INT_CLK_KHZ;
    localparam int SQS_INT_HALF_CYC = SQS_INT_PERIOD_CYC / 2;
    localparam int SQS_REF_PERIOD_NS = 5;
    localparam int SQS_DATA_LEAD_NS = 20;
    localparam int SQS_DATA_LEAD_CYC =
        (SQS_DATA_LEAD_NS + SQS_REF_PERIOD_NS - 1) / SQS_REF_PERIOD_NS;
    localparam int SQS_LEAD_W = $clog2(SQS_DATA_LEAD_CYC + 1);
    localparam logic [SQS_WIDTH-1:0] SQS_SAR_RESET = 16'h0000;

    typedef enum logic [1:0] {
        SQS_IDLE,
        SQS_CLK_LOW,
        SQS_CLK_HIGH,
        SQS_SETTLE
    } sqs_state_t;
endpackage

//--- hdl/sqs_sar_if.sv
// Carrier between the sequencer and its approximation register
`timescale 1ns/1ps
interface sqs_sar_if #(
    parameter int WIDTH = 16
);
    logic init;
    logic trialFirst;
    logic decide;
    logic [sqs_pkg::SQS_STEP_W-1:0] bitIdx;
    logic comp;
    logic [WIDTH-1:0] code;

    modport seq (output init, output trialFirst, output decide, output bitIdx, output comp,
                 input code);
    modport core (input init, input trialFirst, input decide, input bitIdx, input comp,
                  output code);
endinterface

//--- hdl/sqs_sar_core.sv
// Successive approximation register, one trial or decision per step
`timescale 1ns/1ps
module sqs_sar_core #(
    parameter int WIDTH = 16
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    sqs_sar_if.core sarBus
);
    logic [WIDTH-1:0] code_reg;
    logic [WIDTH-1:0] code_next;

    // Position i holds bit number WIDTH-i; bit 1 is the MSB
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++)
        begin : g_bit
            localparam logic [sqs_pkg::SQS_STEP_W-1:0] BITNUM =
                sqs_pkg::SQS_STEP_W'(WIDTH - i);
            always_comb
            begin
                code_next[i] = code_reg[i];
                if (sarBus.init)
                begin
                    code_next[i] = sqs_pkg::SQS_SAR_RESET[i]; // [RULE1]
                end
                else if (sarBus.trialFirst)
                begin
                    // MSB on trial, all others cleared
                    code_next[i] = (i == WIDTH - 1); // [RULE4]
                end
                else if (sarBus.decide)
                begin
                    if (sarBus.bitIdx == BITNUM)
                    begin
                        code_next[i] = sarBus.comp; // [RULE5] [RULE6] [RULE19]
                    end
                    else if (sarBus.bitIdx + 5'h01 == BITNUM)
                    begin
                        code_next[i] = 1'b1; // [RULE5] [RULE7]
                    end
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            code_reg <= sqs_pkg::SQS_SAR_RESET;
        end
        else
        begin
            code_reg <= code_next;
        end
    end

    assign sarBus.code = code_reg;
endmodule // sqs_sar_core

//--- hdl/sqs_conversion_sequencer.sv
// Top of the conversion sequencer: trigger, gated clock, status, result
// What this block does
// RULE1 - Trigger trailing edge clears result, status logic and clock inhibit.
// RULE2 - Status goes high on trigger and stays high during conversion.
// RULE3 - While status high, gated clock runs seventeen cycles at full resolution.
// RULE4 - First step puts MSB on trial, all other bits cleared.
// RULE5 - Step k decides bit k and puts bit k+1 on trial.
// RULE6 - Keep or reject trial bit from comparator at period end.
// RULE7 - Bits are tested one at a time, MSB first.
// RULE8 - Approximation register drives both result outputs and feedback converter.
// RULE9 - After the bit 16 decision status clears: result valid.
// RULE10 - Status clear re-inhibits the clock, held low until next conversion.
// RULE11 - Result bits change only on gated clock rising edges, apart from the trigger trailing-edge clear.
// RULE12 - Result outputs are negative true.
// RULE13 - Coding is inverted straight binary or inverted offset binary.
// RULE14 - Host inverts the MSB to get inverted twos complement.
// RULE15 - Result valid at least 20 ns before status falls.
// RULE16 - Host may capture result on falling status.
// RULE17 - Early-stop input ends the cycle after the chosen number of bits.
// RULE18 - Early stop supports 8,10,12,13,14,15 bits; status clears at that step.
// RULE19 - Comparator is a one-bit input sampled at each decision edge.
// RULE20 - A new trigger restarts the sequence from the start.
`timescale 1ns/1ps
module sqs_conversion_sequencer #(
    parameter int WIDTH = sqs_pkg::SQS_WIDTH,
    parameter int INT_HALF_CYC = sqs_pkg::SQS_INT_HALF_CYC
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic convTrig,
    input wire logic compIn,
    input wire logic earlyStopN,
    output logic status,
    output logic gatedClk,
    output logic [WIDTH-1:0] dataOutN,
    output logic [WIDTH-1:0] dacCode
);
    localparam int DIV_W = $clog2(INT_HALF_CYC + 1);
    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(INT_HALF_CYC - 1);
    localparam logic [sqs_pkg::SQS_STEP_W-1:0] STEP_END =
        sqs_pkg::SQS_STEP_W'(sqs_pkg::SQS_STEPS);
    localparam logic [sqs_pkg::SQS_LEAD_W-1:0] LEAD_LAST =
        sqs_pkg::SQS_LEAD_W'(sqs_pkg::SQS_DATA_LEAD_CYC - 1);

    sqs_pkg::sqs_state_t state_reg;
    sqs_pkg::sqs_state_t state_next;
    logic [DIV_W-1:0] div_reg;
    logic [DIV_W-1:0] div_next;
    logic [sqs_pkg::SQS_STEP_W-1:0] step_reg;
    logic [sqs_pkg::SQS_STEP_W-1:0] step_next;
    logic [sqs_pkg::SQS_LEAD_W-1:0] lead_reg;
    logic [sqs_pkg::SQS_LEAD_W-1:0] lead_next;
    logic status_reg;
    logic status_next;
    logic clk_reg;
    logic clk_next;
    logic trigPrev_reg;
    logic trigFall;

    sqs_sar_if #(.WIDTH(WIDTH)) sarBus ();

    sqs_sar_core #(
        .WIDTH(WIDTH)
    ) u_sar (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .sarBus(sarBus)
    );

    // Only the trailing edge starts a conversion
    assign trigFall = trigPrev_reg & ~convTrig; // [RULE1]

    always_comb
    begin
        state_next = state_reg;
        div_next = div_reg;
        step_next = step_reg;
        lead_next = lead_reg;
        status_next = status_reg;
        clk_next = clk_reg;
        sarBus.init = 1'b0;
        sarBus.trialFirst = 1'b0;
        sarBus.decide = 1'b0;
        sarBus.bitIdx = step_reg;
        sarBus.comp = compIn; // [RULE19]
        if (trigFall)
        begin
            // Restart wins over any phase of a running conversion
            state_next = sqs_pkg::SQS_CLK_LOW; // [RULE20]
            div_next = '0;
            step_next = '0;
            lead_next = '0;
            status_next = 1'b1; // [RULE1] [RULE2]
            clk_next = 1'b0;
            sarBus.init = 1'b1; // [RULE1]
        end
        else
        begin
            unique case (state_reg)
                sqs_pkg::SQS_IDLE:
                begin
                    clk_next = 1'b0; // [RULE10]
                end
                sqs_pkg::SQS_CLK_LOW:
                begin
                    if (div_reg == DIV_LAST)
                    begin
                        // Rising edge of gated clock: apart from the trigger-fall clear, register moves only here
                        div_next = '0;
                        clk_next = 1'b1; // [RULE3] [RULE11]
                        state_next = sqs_pkg::SQS_CLK_HIGH;
                        step_next = step_reg + 5'h01;
                        if (step_reg == 5'h00)
                        begin
                            sarBus.trialFirst = 1'b1; // [RULE4]
                        end
                        else
                        begin
                            sarBus.decide = 1'b1; // [RULE5] [RULE6] [RULE7]
                        end
                    end
                    else
                    begin
                        div_next = div_reg + 1'b1;
                    end
                end
                sqs_pkg::SQS_CLK_HIGH:
                begin
                    if (div_reg == DIV_LAST)
                    begin
                        div_next = '0;
                        clk_next = 1'b0;
                        // Early stop sampled a half period after the edge,
                        // so a tie to a result output has settled
                        if (step_reg == STEP_END) // [RULE3] [RULE9]
                        begin
                            state_next = sqs_pkg::SQS_SETTLE;
                            lead_next = '0;
                        end
                        else if (!earlyStopN && step_reg > 5'h01) // [RULE17] [RULE18]
                        begin
                            state_next = sqs_pkg::SQS_SETTLE;
                            lead_next = '0;
                        end
                        else
                        begin
                            state_next = sqs_pkg::SQS_CLK_LOW;
                        end
                    end
                    else
                    begin
                        div_next = div_reg + 1'b1;
                    end
                end
                sqs_pkg::SQS_SETTLE:
                begin
                    clk_next = 1'b0; // [RULE10]
                    // Hold status so data leads its fall by the margin
                    if (lead_reg == LEAD_LAST) // [RULE15] [RULE16]
                    begin
                        status_next = 1'b0; // [RULE9] [RULE10]
                        state_next = sqs_pkg::SQS_IDLE;
                    end
                    else
                    begin
                        lead_next = lead_reg + 1'b1;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_reg <= sqs_pkg::SQS_IDLE;
            div_reg <= '0;
            step_reg <= '0;
            lead_reg <= '0;
            status_reg <= 1'b0;
            clk_reg <= 1'b0;
            trigPrev_reg <= 1'b0;
        end
        else
        begin
            state_reg <= state_next;
            div_reg <= div_next;
            step_reg <= step_next;
            lead_reg <= lead_next;
            status_reg <= status_next;
            clk_reg <= clk_next;
            trigPrev_reg <= convTrig;
        end
    end

    assign status = status_reg; // [RULE2]
    assign gatedClk = clk_reg;
    // Same register feeds pins and converter; pins are complemented
    assign dacCode = sarBus.code; // [RULE8]
    assign dataOutN = ~sarBus.code; // [RULE8] [RULE12] [RULE13]
endmodule // sqs_conversion_sequencer

//--- dv/sqs_seq_sva.sv
// Port checker of the conversion sequencer
`timescale 1ns/1ps
module sqs_seq_sva #(
    parameter int WIDTH = 16,
    parameter int INT_HALF_CYC = 62
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic convTrig,
    input wire logic compIn,
    input wire logic earlyStopN,
    input wire logic status,
    input wire logic gatedClk,
    input wire logic [WIDTH-1:0] dataOutN,
    input wire logic [WIDTH-1:0] dacCode
);
    logic [WIDTH-1:0] trial;
    logic [4:0] riseCnt_reg;
    logic gPrev_reg;
    logic tPrev_reg;
    logic fallNow;
    assign trial = dacCode & (~dacCode + 1'b1);
    // Trigger fall seen at this edge; the register clears one edge later
    assign fallNow = tPrev_reg && !convTrig;
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            riseCnt_reg <= 5'h00;
            gPrev_reg <= 1'b0;
            tPrev_reg <= 1'b0;
        end
        else
        begin
            gPrev_reg <= gatedClk;
            tPrev_reg <= convTrig;
            if (tPrev_reg && !convTrig)
                riseCnt_reg <= 5'h00;
            else if (gatedClk && !gPrev_reg)
                riseCnt_reg <= riseCnt_reg + 5'h01;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence trigFall; $fell(convTrig); endsequence
    sequence firstTrial; ##INT_HALF_CYC (gatedClk && dacCode == 16'h8000); endsequence
    sequence decision; $rose(gatedClk) && $past(dacCode) != 16'h0000; endsequence
    a_neg_true_out: assert property (dataOutN == ~dacCode)
        else $error("result pins not inverse of register");
    a_trig_init_all: assert property (trigFall |=> status && dacCode == 16'h0000 && !gatedClk)
        else $error("trigger fall did not initialise");
    a_msb_first_trial: assert property (trigFall |=> firstTrial)
        else $error("first step not msb trial");
    a_idle_clk_low: assert property (!status |-> !gatedClk)
        else $error("gated clock runs while idle");
    a_rise_in_conv: assert property ($rose(gatedClk) |-> status)
        else $error("gated clock rose without status");
    a_keep_reject_bit: assert property (decision |-> ((dacCode & $past(trial)) != 16'h0000) == $past(compIn))
        else $error("trial bit decision wrong");
    a_next_trial_set: assert property (decision |-> (dacCode & ($past(trial) >> 1)) == ($past(trial) >> 1))
        else $error("next trial bit not set");
    a_data_lead_status: assert property ($fell(status) |-> $past(dacCode, 4) == dacCode && !$past(gatedClk, 4) && $past(gatedClk, 5))
        else $error("result not settled before status fell");
    a_rise_count_max: assert property ($fell(status) |-> riseCnt_reg >= 5'h02 && riseCnt_reg <= 5'h11)
        else $error("gated clock rise count out of range");
    a_code_on_rise: assert property ($changed(dacCode) |-> $rose(gatedClk) || $past(fallNow))
        else $error("result changed off a gated clock rise");
endmodule // sqs_seq_sva
bind sqs_conversion_sequencer sqs_seq_sva #(.WIDTH(WIDTH), .INT_HALF_CYC(INT_HALF_CYC)) sqs_seq_sva_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .convTrig(convTrig), .compIn(compIn),
    .earlyStopN(earlyStopN), .status(status), .gatedClk(gatedClk),
    .dataOutN(dataOutN), .dacCode(dacCode));

//--- dv/sqs_host_model.sv
// Host side model capturing the result on falling status
`timescale 1ns/1ps
module sqs_host_model (
    input wire logic ref_clk,
    input wire logic status,
    input wire logic [15:0] dataOutN,
    output logic [15:0] capWord,
    output logic [15:0] capTwos
);
    // Fall seen on the system clock, so no extra clock domain
    logic stPrev_reg = 1'b0;
    always_ff @(posedge ref_clk)
    begin
        stPrev_reg <= status;
        if (stPrev_reg && !status)
        begin
            capWord <= dataOutN;
            capTwos <= {~dataOutN[15], dataOutN[14:0]};
        end
    end
endmodule // sqs_host_model

//--- dv/tb.sv
// Self-checking bench of the conversion sequencer
`timescale 1ns/1ps
module tb;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic convTrig = 1'b0;
    logic compIn = 1'b0;
    logic earlyStopN = 1'b1;
    logic status;
    logic gatedClk;
    logic [15:0] dataOutN;
    logic [15:0] dacCode;
    logic [15:0] capWord;
    logic [15:0] capTwos;
    logic [15:0] target = 16'h0000;
    int res = 16;
    int error_cnt = 0;
    int compares = 0;
    int rises = 0;
    sqs_conversion_sequencer #(.WIDTH(16), .INT_HALF_CYC(2)) sqs_conversion_sequencer_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .convTrig(convTrig), .compIn(compIn),
        .earlyStopN(earlyStopN), .status(status), .gatedClk(gatedClk),
        .dataOutN(dataOutN), .dacCode(dacCode));
    sqs_host_model sqs_host_model_inst (.ref_clk(ref_clk), .status(status),
        .dataOutN(dataOutN), .capWord(capWord), .capTwos(capTwos));
    initial forever #2.5 ref_clk = ~ref_clk;
    always @(posedge gatedClk) rises++;
    // Comparator keeps a trial not above the input; early stop wired to a result pin
    always @(posedge ref_clk)
    begin
        #1;
        compIn = (dacCode <= target);
        earlyStopN = (res == 16) ? 1'b1 : dataOutN[15 - res];
    end
    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(inout int w);
        @(posedge ref_clk);
        #1;
        w++;
    endtask
    task automatic pulse(input logic [15:0] t, input int r);
        int w;
        target = t;
        res = r;
        convTrig = 1'b1;
        step(w);
        convTrig = 1'b0;
        rises = 0;
    endtask
    task automatic convert(input logic [15:0] t, input int r);
        int w;
        pulse(t, r);
        w = 0;
        while (status !== 1'b1 && w < 10) step(w);
        while (status === 1'b1 && w < 300) step(w);
        step(w);
        step(w);
        check("status", {15'h0000, status}, 16'h0000);
        check("gatedClk", {15'h0000, gatedClk}, 16'h0000);
    endtask
    task automatic test_full();
        logic [15:0] vals [4] = '{16'h677A, 16'h0000, 16'hFFFF, 16'h8000};
        foreach (vals[i])
        begin
            convert(vals[i], 16);
            check("dataOutN", dataOutN, ~vals[i]);
            check("rises", 16'(rises), 16'h0011);
            check("capWord", capWord, ~vals[i]);
            check("capTwos", capTwos, {vals[i][15], ~vals[i][14:0]});
        end
        $display("test_full done");
    endtask
    task automatic test_early();
        int rl [6] = '{8, 10, 12, 13, 14, 15};
        logic [15:0] e;
        foreach (rl[i])
        begin
            convert(16'hA5C3, rl[i]);
            e = (16'hA5C3 & ~(16'hFFFF >> rl[i])) | (16'h8000 >> rl[i]);
            check("earlyData", dataOutN, ~e);
            check("earlyRises", 16'(rises), 16'(rl[i] + 1));
        end
        $display("test_early done");
    endtask
    task automatic test_restart();
        int w;
        pulse(16'h1234, 16);
        repeat (15) step(w);
        convert(16'hC0DE, 16);
        check("restartData", dataOutN, ~16'hC0DE);
        check("restartRises", 16'(rises), 16'h0011);
        $display("test_restart done");
    endtask
    task automatic test_reset_mid();
        int w;
        pulse(16'h5A5A, 16);
        repeat (20) step(w);
        rst_n = 1'b0;
        step(w);
        check("rstStatus", {15'h0000, status}, 16'h0000);
        check("rstData", dataOutN, 16'hFFFF);
        rst_n = 1'b1;
        step(w);
        convert(16'h0F0F, 16);
        check("afterRst", dataOutN, ~16'h0F0F);
        $display("test_reset_mid done");
    endtask
    task automatic results();
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        repeat (20) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        test_full();
        test_early();
        test_restart();
        test_reset_mid();
        results();
    end
    // Run needs about 900 cycles; generous limit
    initial
    begin
        #100000;
        error_cnt++;
        results();
    end
endmodule // tb
